// ===== design/arrmf_defines.svh
// Contract
// - sixteen or eight sample states per bit
// - bit value is majority of three centre samples
// - voting samples start at 8 or 4
// - receive through first stop bit, ignore others
// - stop bit voted low sets frame error
// - next start edge accepted right after voting
// - filter drops data frames from receive buffer
// - type from stop bit, or ninth bit
// - type one is address, zero is data
// - transmitter ignores filter enable
// - address frames stored and flagged normally
// - master sends ninth bit as frame type
// - slave software toggles filter per address
// - short frames need two stop bits sent
// - one character size for both directions
// - filter enable shares location with tx flag
// - written top bit selects baud or control
// - remote bit rate stays within tolerance
// - sample at sixteen or eight times baud
// - start validated by majority of middle samples
`ifndef ARRMF_DEFINES_SVH
`define ARRMF_DEFINES_SVH
// register indices on the wishbone bus, byte address is index times four
`define ARRMF_REG_DATA      4'h0
`define ARRMF_REG_CSA       4'h1
`define ARRMF_REG_SHARED    4'h2
`define ARRMF_REG_BAUD_LO   4'h3
`define ARRMF_REG_STATUS    4'h4
// ctrl_status_a fields
`define ARRMF_CSA_RX_DONE   7
`define ARRMF_CSA_TX_DONE   6
`define ARRMF_CSA_FRAME_ERR 4
`define ARRMF_CSA_DBL_SPEED 1
`define ARRMF_CSA_FILTER    0
// shared location fields
`define ARRMF_SH_SEL        7
`define ARRMF_SH_TWO_STOP   3
// sampling
`define ARRMF_NORM_SPB      5'h10
`define ARRMF_DBL_SPB       5'h08
`define ARRMF_NORM_FIRST    5'h08
`define ARRMF_DBL_FIRST     5'h04
`define ARRMF_CSC_RESET     8'h06
`define ARRMF_SIZE_NINE     3'h7
`endif

// ===== design/arrmf_pkg.sv
package arrmf_pkg;
	typedef enum logic [1:0]
	{
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10
	} arrmf_rx_state_t;
	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_BITS  = 2'b10
	} arrmf_tx_state_t;
endpackage : arrmf_pkg

// ===== design/arrmf_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface arrmf_link_if;
	logic line;
	modport device_end (input line);
	modport master_end (output line);
endinterface : arrmf_link_if
`default_nettype wire

// ===== design/arrmf_device.sv
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "arrmf_defines.svh"
module arrmf_device
(
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// serial link
	arrmf_link_if.device_end link,
	// transmit-side status and shared settings
	input  wire logic        tx_done_i,
	output logic      [2:0]  char_size_code_o,
	output logic             two_stop_bits_select_o
);
	////////////////////////////////////////////////////////////////////////
	logic        sync1_r, sync2_r;
	logic [11:0] baud_divisor_r;
	logic [7:0]  csc_r;
	logic        multiproc_filter_enable_r;
	logic        double_speed_select_r;
	logic        tx_complete_flag_r;
	logic [8:0]  rbuf_r;
	logic        rfe_r;
	logic        rx_complete_flag_r;
	logic [11:0] bcnt_r;
	logic        tick;
	logic [4:0]  samp_r;
	logic [3:0]  bitn_r;
	logic [1:0]  vote_r;
	logic [8:0]  shift_r;
	arrmf_pkg::arrmf_rx_state_t st_r;
	logic        wr, rd, acc;
	logic [4:0]  spb, first;
	logic [3:0]  ndata;
	logic [2:0]  csz;
	assign acc   = cyc_i & stb_i & ~ack_o;
	assign wr    = acc & we_i & sel_i[0];
	assign rd    = acc & ~we_i;
	assign spb   = double_speed_select_r ? `ARRMF_DBL_SPB : `ARRMF_NORM_SPB;
	assign first = double_speed_select_r ? `ARRMF_DBL_FIRST : `ARRMF_NORM_FIRST;
	assign csz   = csc_r[2:0];
	assign ndata = (csz == `ARRMF_SIZE_NINE) ? 4'h9 : {2'b00, csz[1:0]} + 4'h5;
	function automatic logic maj(input logic [1:0] v, input logic s);
		maj = (v[1] & v[0]) | (v[1] & s) | (v[0] & s);
	endfunction : maj
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i)
	begin
		sync1_r <= rst_i ? 1'b1 : link.line;
		sync2_r <= rst_i ? 1'b1 : sync1_r;
	end
	// sample tick at spb times baud rate
	always_ff @(posedge clk_i)
	begin
		if (rst_i || tick)
			bcnt_r <= 12'h000;
		else
			bcnt_r <= bcnt_r + 12'h001;
	end
	// a lowered divisor must not strand the counter above it
	assign tick = (bcnt_r >= baud_divisor_r);
	////////////////////////////////////////////////////////////////////////
	// receive recovery
	logic done_ev, ftype, stopb, vote_now;
	assign vote_now = maj(vote_r, sync2_r);
	always_ff @(posedge clk_i)
	begin
		done_ev <= 1'b0;
		if (rst_i)
		begin
			st_r    <= arrmf_pkg::RX_IDLE;
			samp_r  <= 5'h00;
			bitn_r  <= 4'h0;
			vote_r  <= 2'b00;
			shift_r <= 9'h000;
			stopb   <= 1'b0;
		end
		else if (tick)
		begin
			case (st_r)
				arrmf_pkg::RX_IDLE:
					if (!sync2_r)
					begin
						st_r   <= arrmf_pkg::RX_START;
						samp_r <= 5'h02;
					end
				arrmf_pkg::RX_START, arrmf_pkg::RX_BITS:
				begin
					samp_r <= samp_r + 5'h01;
					if (samp_r == first)
						vote_r[1] <= sync2_r;
					if (samp_r == first + 5'h01)
						vote_r[0] <= sync2_r;
					if (samp_r == first + 5'h02)
					begin
						if (st_r == arrmf_pkg::RX_START)
						begin
							if (vote_now)
								st_r <= arrmf_pkg::RX_IDLE;
						end
						else if (bitn_r == ndata)
						begin
							stopb   <= vote_now;
							done_ev <= 1'b1;
							st_r    <= arrmf_pkg::RX_IDLE;
						end
						else
						begin
							shift_r <= {vote_now, shift_r[8:1]};
							bitn_r  <= bitn_r + 4'h1;
						end
					end
					if (samp_r == spb)
					begin
						samp_r <= 5'h01;
						if (st_r == arrmf_pkg::RX_START)
						begin
							st_r   <= arrmf_pkg::RX_BITS;
							bitn_r <= 4'h0;
						end
					end
				end
				default: st_r <= arrmf_pkg::RX_IDLE;
			endcase
		end
	end
	logic [8:0] aligned;
	assign aligned = shift_r >> (4'h9 - ndata);
	assign ftype = (csz == `ARRMF_SIZE_NINE) ? aligned[8] : stopb;
	////////////////////////////////////////////////////////////////////////
	// receive buffer and flags
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rbuf_r             <= 9'h000;
			rfe_r              <= 1'b0;
			rx_complete_flag_r <= 1'b0;
		end
		else if (done_ev && (!multiproc_filter_enable_r || ftype))
		begin
			rbuf_r             <= aligned;
			rfe_r              <= ~stopb;
			rx_complete_flag_r <= 1'b1;
		end
		else if (rd && adr_i == `ARRMF_REG_DATA)
			rx_complete_flag_r <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			baud_divisor_r <= 12'h000;
			csc_r          <= `ARRMF_CSC_RESET;
			multiproc_filter_enable_r <= 1'b0;
			double_speed_select_r     <= 1'b0;
			tx_complete_flag_r        <= 1'b0;
		end
		else
		begin
			if (tx_done_i)
				tx_complete_flag_r <= 1'b1;
			else if (wr && adr_i == `ARRMF_REG_CSA && dat_i[`ARRMF_CSA_TX_DONE])
				tx_complete_flag_r <= 1'b0;
			if (wr && adr_i == `ARRMF_REG_CSA)
			begin
				multiproc_filter_enable_r <= dat_i[`ARRMF_CSA_FILTER];
				double_speed_select_r     <= dat_i[`ARRMF_CSA_DBL_SPEED];
			end
			else if (wr && adr_i == `ARRMF_REG_SHARED)
			begin
				if (dat_i[`ARRMF_SH_SEL])
					csc_r <= {1'b0, dat_i[6:0]};
				else
					baud_divisor_r[11:8] <= dat_i[3:0];
			end
			else if (wr && adr_i == `ARRMF_REG_BAUD_LO)
				baud_divisor_r[7:0] <= dat_i[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// bus answer and shared outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o                  <= 1'b0;
			dat_o                  <= 32'h0000_0000;
			char_size_code_o       <= 3'h0;
			two_stop_bits_select_o <= 1'b0;
		end
		else
		begin
			ack_o                  <= acc;
			char_size_code_o       <= csz;
			two_stop_bits_select_o <= csc_r[`ARRMF_SH_TWO_STOP];
			dat_o                  <= 32'h0000_0000;
			if (rd)
			begin
				if (adr_i == `ARRMF_REG_DATA)
					dat_o <= {23'h000000, rbuf_r};
				else if (adr_i == `ARRMF_REG_CSA)
					dat_o <= {24'h000000, rx_complete_flag_r, tx_complete_flag_r, 1'b0, rfe_r, 2'b00,
						double_speed_select_r, multiproc_filter_enable_r};
				else if (adr_i == `ARRMF_REG_SHARED)
					dat_o <= {28'h0000000, baud_divisor_r[11:8]};
				else if (adr_i == `ARRMF_REG_BAUD_LO)
					dat_o <= {24'h000000, baud_divisor_r[7:0]};
				else if (adr_i == `ARRMF_REG_STATUS)
					dat_o <= {24'h000000, csc_r};
			end
		end
	end
endmodule : arrmf_device
`default_nettype wire

// ===== design/arrmf_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "arrmf_defines.svh"
module arrmf_master
(
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// user side
	input  wire logic        send_i,
	input  wire logic [8:0]  data_i,
	input  wire logic        tx_ninth_bit_i,
	input  wire logic [2:0]  char_size_code_i,
	input  wire logic [15:0] bit_cycles_i,
	output logic             busy_o,
	// serial link
	arrmf_link_if.master_end link
);
	////////////////////////////////////////////////////////////////////////
	arrmf_pkg::arrmf_tx_state_t st_r;
	logic [15:0] cnt_r;
	logic [3:0]  left_r;
	logic [11:0] shift_r;
	logic        line_r;
	logic [3:0]  nd;
	assign nd = (char_size_code_i == `ARRMF_SIZE_NINE) ? 4'h9 : {2'b00, char_size_code_i[1:0]} + 4'h5;
	assign link.line = line_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r    <= arrmf_pkg::TX_IDLE;
			cnt_r   <= 16'h0000;
			left_r  <= 4'h0;
			shift_r <= 12'hFFF;
			line_r  <= 1'b1;
			busy_o  <= 1'b0;
		end
		else
		begin
			case (st_r)
				arrmf_pkg::TX_IDLE:
					if (send_i)
					begin
						// data, then ninth bit and two stop bits, or type bit and one stop bit
						if (char_size_code_i == `ARRMF_SIZE_NINE)
							shift_r <= {2'b11, tx_ninth_bit_i, data_i[7:0], 1'b0};
						else
							shift_r <= (({3'b000, data_i} << 4'h1) & ~(12'hFFE << nd))
								| ({11'h000, tx_ninth_bit_i} << (nd + 4'h1))
								| (12'hFFF << (nd + 4'h2));
						shift_r[0] <= 1'b0;
						left_r  <= nd + 4'h2;
						cnt_r   <= 16'h0000;
						st_r    <= arrmf_pkg::TX_BITS;
						busy_o  <= 1'b1;
					end
				arrmf_pkg::TX_BITS:
				begin
					line_r <= shift_r[0];
					if (cnt_r == bit_cycles_i - 16'h0001)
					begin
						cnt_r   <= 16'h0000;
						shift_r <= {1'b1, shift_r[11:1]};
						if (left_r == 4'h0)
						begin
							st_r   <= arrmf_pkg::TX_IDLE;
							busy_o <= 1'b0;
							line_r <= 1'b1;
						end
						else
							left_r <= left_r - 4'h1;
					end
					else
						cnt_r <= cnt_r + 16'h0001;
				end
				default: st_r <= arrmf_pkg::TX_IDLE;
			endcase
		end
	end
endmodule : arrmf_master
`default_nettype wire

// ===== test/arrmf_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module arrmf_asserts
(
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// link
	input wire logic line,
	input wire logic busy_o,
	input wire logic send_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////
	property p_ans; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ans: assert property (p_ans) else $error("ack late");
	property p_pulse; ack_o |=> !ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack long");
	property p_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack no req");
	property p_go; send_i && !busy_o |=> busy_o; endproperty
	a_go: assert property (p_go) else $error("no busy");
	property p_idle; !busy_o |-> line; endproperty
	a_idle: assert property (p_idle) else $error("idle low");
	property p_start; $rose(busy_o) |-> ##[0:2] !line; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_low; $fell(line) |=> !line[*7]; endproperty
	a_low: assert property (p_low) else $error("short low");
	property p_high; $rose(line) |=> line[*7]; endproperty
	a_high: assert property (p_high) else $error("short high");
	property p_len; $rose(busy_o) |=> busy_o[*8]; endproperty
	a_len: assert property (p_len) else $error("short frame");
	////////////////////////////////
	c_frame: cover property ($fell(busy_o));
	c_ack: cover property (ack_o);
	c_edge: cover property ($fell(line));
endmodule : arrmf_asserts
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, send_i, tx9, ack_o, busy_o, tx_done;
	logic [2:0]  csc;
	logic [3:0]  adr_i;
	logic [8:0]  data_i, mk, d;
	logic [15:0] bit_cycles_i;
	logic [31:0] dat_i, dat_o;
	logic [8:0]  q[$];
	int          n_mismatch, n_compared, seed;
	arrmf_link_if link ();
	arrmf_device i_arrmf_device (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o,
		.ack_o, .link(link.device_end), .tx_done_i(tx_done), .char_size_code_o(csc), .two_stop_bits_select_o());
	arrmf_master i_arrmf_master (.clk_i, .rst_i, .send_i, .data_i, .tx_ninth_bit_i(tx9), .char_size_code_i(csc),
		.bit_cycles_i, .busy_o, .link(link.master_end));
	arrmf_asserts i_arrmf_asserts (.clk_i, .rst_i, .line(link.line), .busy_o, .send_i, .cyc_i, .stb_i, .ack_o);
	////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [8:0] s, input logic [8:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("mismatch dat_o exp %h seen %h", e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [8:0] v);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {23'h000000, v};
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [8:0] e);
		q.push_back(e);
		bus(1'b0, a, 9'h000);
	endtask : rd
	task automatic frame(input logic t);
		d = {t, 8'($random(seed))};
		@(posedge clk_i);
		data_i <= d;
		tx9 <= t;
		send_i <= 1'b1;
		@(posedge clk_i);
		send_i <= 1'b0;
		@(posedge clk_i);
		while (busy_o === 1'b1)
			@(posedge clk_i);
	endtask : frame
	////////////////////////////////
	always @(posedge clk_i)
		if (ack_o === 1'b1 && we_i === 1'b0)
			chk(dat_o[8:0] & mk, q.pop_front() & mk);
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		seed = 32'h2E1CB01F;
		{cyc_i, stb_i, we_i, send_i, tx9, tx_done} = 6'h00;
		adr_i = 4'h0;
		dat_i = 32'h0;
		data_i = 9'h000;
		mk = 9'h0FF;
		bit_cycles_i = 16'h0010;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(4'h1, 9'h000);
		tx_done <= 1'b1;
		@(posedge clk_i);
		tx_done <= 1'b0;
		bus(1'b1, 4'h1, 9'h001);
		rd(4'h1, 9'h041);
		bus(1'b1, 4'h1, 9'h040);
		rd(4'h1, 9'h000);
		rd(4'h4, 9'h006);
		bus(1'b1, 4'h2, 9'h005);
		rd(4'h2, 9'h005);
		rd(4'h4, 9'h006);
		bus(1'b1, 4'h2, 9'h000);
		bus(1'b1, 4'h2, 9'h08B);
		rd(4'h4, 9'h00B);
		rd(4'h2, 9'h000);
		bus(1'b1, 4'h1, 9'h001);
		frame(1'b0);
		rd(4'h1, 9'h001);
		frame(1'b1);
		rd(4'h1, 9'h081);
		rd(4'h0, d);
		bus(1'b1, 4'h1, 9'h000);
		frame(1'b0);
		rd(4'h1, 9'h090);
		rd(4'h0, d);
		bus(1'b1, 4'h2, 9'h087);
		mk = 9'h1FF;
		for (int s = 0; s < 2; s++)
		begin
			bit_cycles_i <= s ? 16'h0008 : 16'h0010;
			bus(1'b1, 4'h1, {7'h00, s[0], 1'b1});
			frame(1'b0);
			rd(4'h1, {4'h0, ~s[0], 2'b00, s[0], 1'b1});
			frame(1'b1);
			rd(4'h1, {7'h20, s[0], 1'b1});
			rd(4'h0, d);
			bus(1'b1, 4'h1, {7'h00, s[0], 1'b0});
			frame(1'b0);
			frame(1'b1);
			rd(4'h1, {7'h20, s[0], 1'b0});
			rd(4'h0, d);
		end
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
